// ---- hw/fsp_device.sv ----
// Functional notes
// R01 - flash writable serially or by self-programming
// R02 - serial path: clock, data, master clear
// R03 - erase and program one 32-word row
// R04 - low table ops reach bits 15:0
// R05 - high table ops reach bits 23:16
// R06 - address is page byte joined to offset
// R07 - rows of 32 words, panels of 128
// R08 - each panel owns 32 write latches
// R09 - software fills latches before programming
// R10 - latches fill in ascending order
// R11 - latch fill starts on 32-word boundary
// R12 - 32 low plus 32 high writes fill row
// R13 - table write two cycles, latches only
// R14 - array changes only after started operation; here a serial frame writes its word to the array directly
// R15 - four control registers: control, addresses, key
// R16 - control selects operation, holds start bit
// R17 - programming works in normal operation
// R18 - key 0x55 then 0xAA before start
// R19 - start bit self-clears when done
// R20 - address registers capture last table address
// R21 - operation lasts 2 ms, core stalled
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "fsp_defs.svh"
module fsp_device #(
	parameter int OP_CYCLES  = `FSP_OP_CYCLES,
	parameter int PANEL_BITS = 1
) (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	fsp_if.device     link,
	output logic      flash_busy,
	output logic      flash_error
);
	import fsp_pkg::*;

	localparam int AW = `FSP_PANEL_LSB - `FSP_WORD_LSB + PANEL_BITS;

	logic [23:0]          flash_mem [0:(1 << AW) - 1];
	logic [23:0]          latch_mem [0:(1 << PANEL_BITS) - 1][0:`FSP_ROW_WORDS - 1];

	logic [15:0]          con_r;
	logic [15:0]          con_nxt;
	logic [15:0]          adrl_r;
	logic [15:0]          adrl_nxt;
	logic [7:0]           adrh_r;
	logic [7:0]           adrh_nxt;
	fsp_key_t             key_r;
	fsp_key_t             key_nxt;
	logic [4:0]           ptr_r;
	logic [4:0]           ptr_nxt;
	fsp_seq_t             seq_r;
	fsp_seq_t             seq_nxt;
	logic [4:0]           cidx_r;
	logic [4:0]           cidx_nxt;
	logic [15:0]          rdata_r;
	logic [15:0]          rdata_nxt;
	logic                 done_r;
	logic                 done_nxt;
	logic                 tw_r;
	logic                 tw_nxt;
	logic                 op_start;
	logic                 op_expire;
	logic [46:0]          sh_r;
	logic [46:0]          sh_nxt;
	logic [5:0]           scnt_r;
	logic [5:0]           scnt_nxt;
	logic                 sclk_q_r;
	logic                 ser_rise;
	logic                 ser_fire;
	logic [47:0]          ser_word;

	logic                 take;
	logic [23:0]          full_addr;
	logic [AW-1:0]        waddr;
	logic [23:0]          rd_word;
	logic [15:0]          rd_low;
	logic [15:0]          rd_high;
	logic [23:0]          nvm_addr;
	logic [AW-1:0]        commit_a;
	logic [PANEL_BITS-1:0] tbl_panel;
	logic [PANEL_BITS-1:0] commit_p;
	logic                 op_ok;
	logic [1:0]           sel;

	// 2 ms operation timer
	fsp_timer #(
		.CYCLES (OP_CYCLES)
	) u_timer (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.start   (op_start),
		.expire  (op_expire)
	);

	// address forming and read data selection
	assign full_addr = {link.table_page_reg, link.effective_address};    // see R06
	assign waddr     = full_addr[`FSP_WORD_LSB +: AW];                     // see R07
	assign tbl_panel = full_addr[`FSP_PANEL_LSB +: PANEL_BITS];            // see R08
	assign nvm_addr  = {adrh_r, adrl_r};
	assign commit_a  = {nvm_addr[`FSP_ROW_LSB +: AW - 5], cidx_r};          // see R03
	assign commit_p  = nvm_addr[`FSP_PANEL_LSB +: PANEL_BITS];
	assign rd_word   = flash_mem[waddr];
	assign rd_low    = link.byte_mode ?
		{8'h00, (link.byte_hi ? rd_word[15:8] : rd_word[7:0])} : rd_word[15:0];  // see R04
	assign rd_high   = (link.byte_mode && link.byte_hi) ?
		16'h0000 : {8'h00, rd_word[23:16]};                                 // see R05
	assign op_ok     = (link.wdata[6:0] == `FSP_PROGOP_ERASE) ||
		(link.wdata[6:0] == `FSP_PROGOP_PROG);
	assign sel       = link.effective_address[1:0];
	// core stalls while an operation runs; requests are taken only when idle
	assign take      = link.req && (seq_r == SEQ_IDLE);                     // see R21

	// serial path samples data on rising programming clock while held in clear
	assign ser_rise  = link.serial_prog_clock && !sclk_q_r;
	assign ser_fire  = !link.master_clear_pin_n && ser_rise && (scnt_r == `FSP_SER_LAST);
	assign ser_word  = {sh_r, link.serial_prog_data};

	// register accesses, key sequence and operation sequencer
	always_comb
	begin
		con_nxt   = con_r;
		adrl_nxt  = adrl_r;
		adrh_nxt  = adrh_r;
		key_nxt   = key_r;
		ptr_nxt   = ptr_r;
		seq_nxt   = seq_r;
		cidx_nxt  = cidx_r;
		rdata_nxt = rdata_r;
		done_nxt  = tw_r;                                     // see R13
		tw_nxt    = 1'b0;
		op_start  = 1'b0;
		if (take)
		begin
			if (link.op inside {OP_TABLE_READ_LOW, OP_TABLE_READ_HIGH,
				OP_TABLE_WRITE_LOW, OP_TABLE_WRITE_HIGH})
			begin
				adrl_nxt = link.effective_address;           // see R20
				adrh_nxt = link.table_page_reg;              // see R20
			end
			case (link.op)
				OP_TABLE_READ_LOW:
				begin
					rdata_nxt = rd_low;
					done_nxt  = 1'b1;
				end
				OP_TABLE_READ_HIGH:
				begin
					rdata_nxt = rd_high;
					done_nxt  = 1'b1;
				end
				OP_TABLE_WRITE_LOW:
					tw_nxt = 1'b1;
				OP_TABLE_WRITE_HIGH:
				begin
					tw_nxt  = 1'b1;
					ptr_nxt = ptr_r + 5'h01;                 // see R10
				end
				OP_SFR_READ:
				begin
					done_nxt = 1'b1;
					case (sel)
						`FSP_SFR_CON:  rdata_nxt = con_r;       // see R15
						`FSP_SFR_ADRL: rdata_nxt = adrl_r;
						`FSP_SFR_ADRH: rdata_nxt = {8'h00, adrh_r};
						default:       rdata_nxt = 16'h0000;    // key is write-only
					endcase
				end
				OP_SFR_WRITE:
				begin
					done_nxt = 1'b1;
					if (sel != `FSP_SFR_KEY)
						key_nxt = KEY_LOCKED;                    // see R18
					case (sel)
						`FSP_SFR_CON:
						begin
							con_nxt = (con_r & ~`FSP_CON_WMASK) | (link.wdata & `FSP_CON_WMASK);
							if (link.wdata[`FSP_CON_WR])
							begin
								// start only after unlock, with writes enabled
								if (key_r == KEY_OPEN && link.wdata[`FSP_CON_WREN] && op_ok)
								begin
									con_nxt[`FSP_CON_WR] = 1'b1;   // see R16
									seq_nxt  = SEQ_TIMING;         // see R14
									op_start = 1'b1;               // see R21
								end
								else
									con_nxt[`FSP_CON_WRERR] = 1'b1; // see R18
							end
						end
						`FSP_SFR_ADRL: adrl_nxt = link.wdata;
						`FSP_SFR_ADRH: adrh_nxt = link.wdata[7:0];
						default:
						begin
							if (link.wdata[7:0] == `FSP_KEY_FIRST)
								key_nxt = KEY_HALF;                 // see R18
							else if (key_r == KEY_HALF && link.wdata[7:0] == `FSP_KEY_SECOND)
								key_nxt = KEY_OPEN;                 // see R18
							else
								key_nxt = KEY_LOCKED;
						end
					endcase
				end
				default: ;
			endcase
		end
		case (seq_r)
			SEQ_TIMING:
				if (op_expire)
				begin
					seq_nxt  = SEQ_COMMIT;
					cidx_nxt = 5'h00;
				end
			SEQ_COMMIT:
			begin
				cidx_nxt = cidx_r + 5'h01;
				if (cidx_r == `FSP_ROW_LAST)
				begin
					seq_nxt = SEQ_IDLE;
					con_nxt[`FSP_CON_WR] = 1'b0;              // see R19
					ptr_nxt = 5'h00;                           // see R11
				end
			end
			default: ;
		endcase
	end

	// serial shift state
	always_comb
	begin
		sh_nxt   = sh_r;
		scnt_nxt = scnt_r;
		if (link.master_clear_pin_n)
			scnt_nxt = 6'h00;
		else if (ser_rise)
		begin
			sh_nxt   = ser_word[46:0];                          // see R02
			scnt_nxt = (scnt_r == `FSP_SER_LAST) ? 6'h00 : scnt_r + 6'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			con_r    <= `FSP_CON_RESET;
			adrl_r   <= 16'h0000;
			adrh_r   <= 8'h00;
			key_r    <= KEY_LOCKED;
			ptr_r    <= 5'h00;
			seq_r    <= SEQ_IDLE;
			cidx_r   <= 5'h00;
			rdata_r  <= 16'h0000;
			done_r   <= 1'b0;
			tw_r     <= 1'b0;
			sh_r     <= 47'h0;
			scnt_r   <= 6'h00;
			sclk_q_r <= 1'b0;
		end
		else
		begin
			con_r    <= con_nxt;
			adrl_r   <= adrl_nxt;
			adrh_r   <= adrh_nxt;
			key_r    <= key_nxt;
			ptr_r    <= ptr_nxt;
			seq_r    <= seq_nxt;
			cidx_r   <= cidx_nxt;
			rdata_r  <= rdata_nxt;
			done_r   <= done_nxt;
			tw_r     <= tw_nxt;
			sh_r     <= sh_nxt;
			scnt_r   <= scnt_nxt;
			sclk_q_r <= link.serial_prog_clock;
		end
	end

	// array and latch storage; table writes touch latches only
	always_ff @(posedge ref_clk)
	begin
		if (seq_r == SEQ_COMMIT)
			flash_mem[commit_a] <= (con_r[6:0] == `FSP_PROGOP_ERASE) ?
				`FSP_ERASED : latch_mem[commit_p][cidx_r];       // see R03
		else if (ser_fire)
			flash_mem[ser_word[24 + `FSP_WORD_LSB +: AW]] <= ser_word[23:0];  // see R01
		if (take && link.op == OP_TABLE_WRITE_LOW)
		begin
			if (!link.byte_mode)
				latch_mem[tbl_panel][ptr_r][15:0] <= link.wdata;          // see R13
			else if (link.byte_hi)
				latch_mem[tbl_panel][ptr_r][15:8] <= link.wdata[7:0];
			else
				latch_mem[tbl_panel][ptr_r][7:0] <= link.wdata[7:0];
		end
		if (take && link.op == OP_TABLE_WRITE_HIGH && !(link.byte_mode && link.byte_hi))
			latch_mem[tbl_panel][ptr_r][23:16] <= link.wdata[7:0];   // see R05
	end

	// outputs; serial data line is never driven by this end
	assign link.rdata       = rdata_r;
	assign link.done        = done_r;
	assign link.stall       = (seq_r != SEQ_IDLE);                // see R17
	assign link.dev_data_o  = 1'b0;
	assign link.dev_data_oe = 1'b0;
	assign flash_busy       = (seq_r != SEQ_IDLE);
	assign flash_error      = con_r[`FSP_CON_WRERR];
endmodule // fsp_device

// ---- hw/fsp_defs.svh ----
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

// timing
`define FSP_CLK_PERIOD_NS   20
`define FSP_OP_TIME_NS      2000000
`define FSP_OP_CYCLES       (`FSP_OP_TIME_NS / `FSP_CLK_PERIOD_NS)
`define FSP_SCLK_HALF       4

// program memory geometry, instruction address steps by two
`define FSP_ROW_WORDS       32
`define FSP_ROW_LAST        5'h1F
`define FSP_WORD_LSB        1
`define FSP_ROW_LSB         6
`define FSP_PANEL_LSB       13
`define FSP_ERASED          24'hFFFFFF

// control register fields
`define FSP_CON_WR          15
`define FSP_CON_WREN        14
`define FSP_CON_WRERR       13
`define FSP_CON_RESET       16'h0000
`define FSP_CON_WMASK       16'h617F
`define FSP_PROGOP_ERASE    7'h41
`define FSP_PROGOP_PROG     7'h01

// unlock key bytes
`define FSP_KEY_FIRST       8'h55
`define FSP_KEY_SECOND      8'hAA

// special register selects, carried in effective address bits 1:0
`define FSP_SFR_CON         2'h0
`define FSP_SFR_ADRL        2'h1
`define FSP_SFR_ADRH        2'h2
`define FSP_SFR_KEY         2'h3

// serial frame: 24 address bits then 24 data bits, msb first
`define FSP_SER_LAST        6'h2F
`define FSP_SER_BITS        48

// host register offsets
`define FSP_HR_CMD          8'h00
`define FSP_HR_PAGE         8'h04
`define FSP_HR_EA           8'h08
`define FSP_HR_WDATA        8'h0C
`define FSP_HR_STAT         8'h10
`define FSP_HR_RDATA        8'h14
`define FSP_HR_SADDR        8'h18
`define FSP_HR_SDATA        8'h1C
`define FSP_HR_SCTL         8'h20

`endif

// ---- hw/fsp_pkg.sv ----
package fsp_pkg;

	typedef enum logic [2:0] {
		OP_TABLE_READ_LOW   = 3'h0,
		OP_TABLE_READ_HIGH  = 3'h1,
		OP_TABLE_WRITE_LOW  = 3'h2,
		OP_TABLE_WRITE_HIGH = 3'h3,
		OP_SFR_READ         = 3'h4,
		OP_SFR_WRITE        = 3'h5
	} fsp_op_t;

	typedef enum logic [1:0] {
		SEQ_IDLE   = 2'b00,
		SEQ_TIMING = 2'b01,
		SEQ_COMMIT = 2'b11
	} fsp_seq_t;

	typedef enum logic [1:0] {
		KEY_LOCKED = 2'b00,
		KEY_HALF   = 2'b01,
		KEY_OPEN   = 2'b11
	} fsp_key_t;

	typedef enum logic [1:0] {
		HST_IDLE = 2'b00,
		HST_PEND = 2'b01,
		HST_WAIT = 2'b11
	} fsp_hst_t;

endpackage

// ---- hw/fsp_if.sv ----
`timescale 1ns/1ps
interface fsp_if;
	logic                req;
	fsp_pkg::fsp_op_t    op;
	logic                byte_mode;
	logic                byte_hi;
	logic [7:0]          table_page_reg;
	logic [15:0]         effective_address;
	logic [15:0]         wdata;
	logic [15:0]         rdata;
	logic                done;
	logic                stall;
	logic                serial_prog_clock;
	logic                master_clear_pin_n;
	logic                host_data_o;
	logic                host_data_oe;
	logic                dev_data_o;
	logic                dev_data_oe;
	logic                serial_prog_data;

	// resolved data line, pulled high when nobody drives
	assign serial_prog_data = host_data_oe ? host_data_o : (dev_data_oe ? dev_data_o : 1'b1);

	modport device (
		input  req, op, byte_mode, byte_hi, table_page_reg, effective_address, wdata,
		input  serial_prog_clock, master_clear_pin_n, serial_prog_data,
		output rdata, done, stall, dev_data_o, dev_data_oe
	);

	modport host (
		output req, op, byte_mode, byte_hi, table_page_reg, effective_address, wdata,
		output serial_prog_clock, master_clear_pin_n, host_data_o, host_data_oe,
		input  rdata, done, stall, serial_prog_data
	);
endinterface

// ---- hw/fsp_timer.sv ----
`timescale 1ns/1ps
`include "fsp_defs.svh"
module fsp_timer #(
	parameter int CYCLES = `FSP_OP_CYCLES
) (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic start,
	output logic      expire
);
	import fsp_pkg::*;

	localparam int CW = $clog2(CYCLES + 1);

	logic          run_r;
	logic          run_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;

	// expire pulses exactly CYCLES edges after start
	assign expire = run_r && (cnt_r == '0);

	// down counter
	always_comb
	begin
		run_nxt = run_r;
		cnt_nxt = cnt_r;
		if (start)
		begin
			run_nxt = 1'b1;
			cnt_nxt = CW'(CYCLES - 1);
		end
		else if (expire)
			run_nxt = 1'b0;
		else if (run_r)
			cnt_nxt = cnt_r - CW'(1);
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			run_r <= 1'b0;
			cnt_r <= '0;
		end
		else
		begin
			run_r <= run_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule // fsp_timer

// ---- hw/fsp_host.sv ----
`timescale 1ns/1ps
`include "fsp_defs.svh"
module fsp_host #(
	parameter int SCLK_HALF = `FSP_SCLK_HALF
) (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	fsp_if.host              link
);
	import fsp_pkg::*;

	localparam int DW = $clog2(SCLK_HALF + 1);

	fsp_hst_t    hst_r;
	fsp_hst_t    hst_nxt;
	fsp_op_t     op_r;
	fsp_op_t     op_nxt;
	logic [1:0]  bm_r;
	logic [1:0]  bm_nxt;
	logic [7:0]  page_r;
	logic [7:0]  page_nxt;
	logic [15:0] ea_r;
	logic [15:0] ea_nxt;
	logic [15:0] wd_r;
	logic [15:0] wd_nxt;
	logic [15:0] res_r;
	logic [15:0] res_nxt;
	logic [23:0] sadr_r;
	logic [23:0] sadr_nxt;
	logic        master_clear_pin_r;
	logic        master_clear_pin_nxt;
	logic [47:0] sh_r;
	logic [47:0] sh_nxt;
	logic [5:0]  scnt_r;
	logic [5:0]  scnt_nxt;
	logic        sclk_r;
	logic        sclk_nxt;
	logic        sbusy_r;
	logic        sbusy_nxt;
	logic [DW-1:0] div_r;
	logic [DW-1:0] div_nxt;
	logic        tick;
	logic [31:0] rd_nxt;
	logic [31:0] rd_r;

	// divider enable for the programming clock
	assign tick = (div_r == DW'(SCLK_HALF - 1));

	// command registers, request handshake and serial shifter
	always_comb
	begin
		hst_nxt   = hst_r;
		op_nxt    = op_r;
		bm_nxt    = bm_r;
		page_nxt  = page_r;
		ea_nxt    = ea_r;
		wd_nxt    = wd_r;
		res_nxt   = res_r;
		sadr_nxt  = sadr_r;
		master_clear_pin_nxt  = master_clear_pin_r;
		sh_nxt    = sh_r;
		scnt_nxt  = scnt_r;
		sclk_nxt  = sclk_r;
		sbusy_nxt = sbusy_r;
		div_nxt   = sbusy_r ? (tick ? '0 : div_r + DW'(1)) : '0;
		if (reg_wr)
		begin
			case (reg_addr)
				`FSP_HR_CMD:
					if (hst_r == HST_IDLE)
					begin
						op_nxt  = fsp_op_t'(reg_wdata[2:0]);
						bm_nxt  = reg_wdata[4:3];
						hst_nxt = HST_PEND;
					end
				`FSP_HR_PAGE:  page_nxt = reg_wdata[7:0];
				`FSP_HR_EA:    ea_nxt   = reg_wdata[15:0];
				`FSP_HR_WDATA: wd_nxt   = reg_wdata[15:0];
				`FSP_HR_SADDR: sadr_nxt = reg_wdata[23:0];
				`FSP_HR_SCTL:  master_clear_pin_nxt = reg_wdata[0];
				`FSP_HR_SDATA:
					if (!sbusy_r && master_clear_pin_r)
					begin
						sh_nxt    = {sadr_r, reg_wdata[23:0]};
						scnt_nxt  = `FSP_SER_LAST;
						sbusy_nxt = 1'b1;
						sclk_nxt  = 1'b0;
					end
				default: ;
			endcase
		end
		// request goes out only while the device is not stalling
		case (hst_r)
			HST_PEND: if (!link.stall) hst_nxt = HST_WAIT;    // see R21
			HST_WAIT:
				if (link.done)
				begin
					hst_nxt = HST_IDLE;
					res_nxt = link.rdata;
				end
			default: ;
		endcase
		// data changes on falling clock, device samples on rising
		if (sbusy_r && tick)
		begin
			sclk_nxt = !sclk_r;                                // see R02
			if (sclk_r)
			begin
				sh_nxt   = {sh_r[46:0], 1'b0};
				scnt_nxt = scnt_r - 6'h01;
				if (scnt_r == 6'h00)
					sbusy_nxt = 1'b0;
			end
		end
	end

	// register read mux
	always_comb
	begin
		rd_nxt = 32'h00000000;
		if (reg_rd)
		begin
			case (reg_addr)
				`FSP_HR_CMD:   rd_nxt = {27'h0, bm_r, op_r};
				`FSP_HR_PAGE:  rd_nxt = {24'h0, page_r};
				`FSP_HR_EA:    rd_nxt = {16'h0, ea_r};
				`FSP_HR_WDATA: rd_nxt = {16'h0, wd_r};
				`FSP_HR_STAT:  rd_nxt = {29'h0, sbusy_r, link.stall, hst_r != HST_IDLE};
				`FSP_HR_RDATA: rd_nxt = {16'h0, res_r};
				`FSP_HR_SADDR: rd_nxt = {8'h00, sadr_r};
				`FSP_HR_SCTL:  rd_nxt = {31'h0, master_clear_pin_r};
				default:       rd_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hst_r   <= HST_IDLE;
			op_r    <= OP_TABLE_READ_LOW;
			bm_r    <= 2'h0;
			page_r  <= 8'h00;
			ea_r    <= 16'h0000;
			wd_r    <= 16'h0000;
			res_r   <= 16'h0000;
			sadr_r  <= 24'h000000;
			master_clear_pin_r  <= 1'b0;
			sh_r    <= 48'h0;
			scnt_r  <= 6'h00;
			sclk_r  <= 1'b0;
			sbusy_r <= 1'b0;
			div_r   <= '0;
			rd_r    <= 32'h00000000;
		end
		else
		begin
			hst_r   <= hst_nxt;
			op_r    <= op_nxt;
			bm_r    <= bm_nxt;
			page_r  <= page_nxt;
			ea_r    <= ea_nxt;
			wd_r    <= wd_nxt;
			res_r   <= res_nxt;
			sadr_r  <= sadr_nxt;
			master_clear_pin_r  <= master_clear_pin_nxt;
			sh_r    <= sh_nxt;
			scnt_r  <= scnt_nxt;
			sclk_r  <= sclk_nxt;
			sbusy_r <= sbusy_nxt;
			div_r   <= div_nxt;
			rd_r    <= rd_nxt;
		end
	end

	// link drive
	assign link.req                = (hst_r == HST_PEND) && !link.stall;
	assign link.op                 = op_r;
	assign link.byte_mode          = bm_r[0];
	assign link.byte_hi            = bm_r[1];
	assign link.table_page_reg     = page_r;
	assign link.effective_address  = ea_r;
	assign link.wdata              = wd_r;
	assign link.serial_prog_clock  = sclk_r;
	assign link.master_clear_pin_n = !master_clear_pin_r;
	assign link.host_data_o        = sh_r[47];
	assign link.host_data_oe       = sbusy_r;
	assign reg_rdata               = rd_r;
endmodule // fsp_host

// ---- test/fsp_checker.sv ----
`timescale 1ns/1ps
module fsp_checker #(
	parameter int OP_CYCLES = 20
) (
	input wire logic             ref_clk,
	input wire logic             reset_n,
	input wire logic             req,
	input wire fsp_pkg::fsp_op_t op,
	input wire logic [15:0]      effective_address,
	input wire logic [15:0]      wdata,
	input wire logic [15:0]      rdata,
	input wire logic             done,
	input wire logic             stall,
	input wire logic             serial_prog_clock,
	input wire logic             master_clear_pin_n
);
	import fsp_pkg::*;
	localparam int STALL_MAX = OP_CYCLES + 40;
	logic [15:0] stall_cnt_r;
	logic [15:0] stall_cnt_nxt;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// length of the current stall
	always_comb
	begin
		stall_cnt_nxt = stall ? stall_cnt_r + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			stall_cnt_r <= 16'h0000;
		else
			stall_cnt_r <= stall_cnt_nxt;
	end

	// link handshake
	property p_req_idle; req |-> !stall; endproperty
	a_req_idle: assert property (p_req_idle) else $error("request while stalled");
	property p_quick; req && op != OP_TABLE_WRITE_LOW && op != OP_TABLE_WRITE_HIGH |=> done; endproperty
	a_quick: assert property (p_quick) else $error("read or sfr not done");
	property p_twrite; req && (op == OP_TABLE_WRITE_LOW || op == OP_TABLE_WRITE_HIGH) |=> !done ##1 done; endproperty
	a_twrite: assert property (p_twrite) else $error("table write not two cycles");
	property p_hold; req ##1 !done |-> $stable(op) && $stable(effective_address) && $stable(wdata); endproperty
	a_hold: assert property (p_hold) else $error("request dropped early");
	property p_pulse; done |=> !done; endproperty
	a_pulse: assert property (p_pulse) else $error("done too long");
	property p_rdata; $changed(rdata) |-> done; endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved");
	// programming operation
	property p_start; $rose(stall) |-> done && op == OP_SFR_WRITE && effective_address[1:0] == 2'h0; endproperty
	a_start: assert property (p_start) else $error("stall without start");
	property p_end; $rose(stall) |-> ##[1:STALL_MAX] !stall; endproperty
	a_end: assert property (p_end) else $error("operation too long");
	property p_len; $fell(stall) |-> int'(stall_cnt_r) >= OP_CYCLES; endproperty
	a_len: assert property (p_len) else $error("operation too short");
	property p_serial; $rose(serial_prog_clock) |-> !master_clear_pin_n; endproperty
	a_serial: assert property (p_serial) else $error("serial clock outside hold");
endmodule // fsp_checker

// ---- test/flash_self_programming_tb.sv ----
`timescale 1ns/1ps
`include "fsp_defs.svh"
module flash_self_programming_tb;
	import fsp_pkg::*;
	typedef struct packed {
		fsp_op_t     op;
		logic [15:0] ea;
		logic [15:0] wd;
		logic        cmp;
		logic [15:0] exp;
	} fsp_row_t;
	localparam logic [15:0] ROWA = 16'h0040;
	logic        ref_clk;
	logic        reset_n;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        flash_busy;
	logic        flash_error;
	logic [31:0] v;
	int          err_total;
	int          checked;
	fsp_row_t    rows [19];

	fsp_if fsp_if_i ();
	fsp_host #(.SCLK_HALF(1)) fsp_host_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .link(fsp_if_i.host));
	fsp_device #(.OP_CYCLES(20), .PANEL_BITS(1)) fsp_device_i (.ref_clk(ref_clk),
		.reset_n(reset_n), .link(fsp_if_i.device), .flash_busy(flash_busy),
		.flash_error(flash_error));
	fsp_checker #(.OP_CYCLES(20)) fsp_checker_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.req(fsp_if_i.req), .op(fsp_if_i.op), .effective_address(fsp_if_i.effective_address),
		.wdata(fsp_if_i.wdata), .rdata(fsp_if_i.rdata), .done(fsp_if_i.done),
		.stall(fsp_if_i.stall), .serial_prog_clock(fsp_if_i.serial_prog_clock),
		.master_clear_pin_n(fsp_if_i.master_clear_pin_n));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// poll a status bit until it drops, bounded
	task automatic wait_clear(input int b);
		v = 32'hFFFFFFFF;
		for (int n = 0; n < 300 && v[b] !== 1'b0; n++)
			rd(`FSP_HR_STAT, v);
		chk({31'h00000000, v[b]}, 32'h00000000);
	endtask
	task automatic run(input fsp_op_t op, input logic [15:0] ea, input logic [15:0] wd,
		input logic [1:0] bm);
		wr(`FSP_HR_EA, {16'h0000, ea});
		wr(`FSP_HR_WDATA, {16'h0000, wd});
		wr(`FSP_HR_CMD, {27'h0000000, bm, op});
		wait_clear(0);
	endtask
	task automatic end_of_test();
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// free-running clock
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// watchdog
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		end_of_test();
	end

	// main sequence
	initial
	begin
		reset_n   = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 32'h00000000;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		err_total = 0;
		checked   = 0;
		rows = '{
			'{OP_SFR_WRITE, 16'h0001, ROWA, 1'b0, 16'h0000},
			'{OP_SFR_READ, 16'h0001, 16'h0000, 1'b1, ROWA},
			'{OP_SFR_WRITE, 16'h0000, 16'hC041, 1'b0, 16'h0000},
			'{OP_SFR_READ, 16'h0000, 16'h0000, 1'b1, 16'h6041},
			'{OP_SFR_WRITE, 16'h0003, 16'h0055, 1'b0, 16'h0000},
			'{OP_SFR_WRITE, 16'h0001, ROWA, 1'b0, 16'h0000},
			'{OP_SFR_WRITE, 16'h0003, 16'h00AA, 1'b0, 16'h0000},
			'{OP_SFR_WRITE, 16'h0000, 16'hC041, 1'b0, 16'h0000},
			'{OP_SFR_READ, 16'h0000, 16'h0000, 1'b1, 16'h6041},
			'{OP_SFR_READ, 16'h0003, 16'h0000, 1'b1, 16'h0000},
			'{OP_SFR_WRITE, 16'h0000, 16'h4041, 1'b0, 16'h0000},
			'{OP_SFR_WRITE, 16'h0003, 16'h0055, 1'b0, 16'h0000},
			'{OP_SFR_WRITE, 16'h0003, 16'h00AA, 1'b0, 16'h0000},
			'{OP_SFR_WRITE, 16'h0000, 16'hC041, 1'b0, 16'h0000},
			'{OP_SFR_READ, 16'h0000, 16'h0000, 1'b1, 16'h4041},
			'{OP_TABLE_READ_LOW, ROWA, 16'h0000, 1'b1, 16'hFFFF},
			'{OP_TABLE_READ_HIGH, ROWA, 16'h0000, 1'b1, 16'h00FF},
			'{OP_TABLE_READ_LOW, ROWA + 16'h003E, 16'h0000, 1'b1, 16'hFFFF},
			'{OP_SFR_READ, 16'h0001, 16'h0000, 1'b1, ROWA + 16'h003E}};
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(`FSP_HR_STAT, v);
		chk(v, 32'h00000000);
		chk({30'h00000000, fsp_if_i.master_clear_pin_n, fsp_if_i.serial_prog_data}, 32'h00000003);
		// key, refusal, erase and address capture
		foreach (rows[i])
		begin
			run(rows[i].op, rows[i].ea, rows[i].wd, 2'b00);
			if (i == 2)
				chk({31'h00000000, flash_error}, 32'h00000001);
			rd(`FSP_HR_RDATA, v);
			if (rows[i].cmp)
				chk(v, {16'h0000, rows[i].exp});
		end
		chk({31'h00000000, flash_error}, 32'h00000000);
		// fill one row of latches in order
		for (int i = 0; i < 32; i++)
		begin
			run(OP_TABLE_WRITE_LOW, ROWA + 16'(2 * i), 16'hA500 + 16'(i), 2'b00);
			run(OP_TABLE_WRITE_HIGH, ROWA + 16'(2 * i), 16'h00C0 + 16'(i), 2'b00);
		end
		run(OP_TABLE_READ_LOW, ROWA, 16'h0000, 2'b00);
		rd(`FSP_HR_RDATA, v);
		chk(v, 32'h0000FFFF);
		run(OP_SFR_WRITE, 16'h0003, 16'h0055, 2'b00);
		run(OP_SFR_WRITE, 16'h0003, 16'h00AA, 2'b00);
		run(OP_SFR_WRITE, 16'h0000, 16'hC001, 2'b00);
		rd(`FSP_HR_STAT, v);
		chk({30'h00000000, v[1], flash_busy}, 32'h00000003);
		for (int i = 0; i < 32; i++)
		begin
			run(OP_TABLE_READ_LOW, ROWA + 16'(2 * i), 16'h0000, 2'b00);
			rd(`FSP_HR_RDATA, v);
			chk(v, 32'h0000A500 + 32'(i));
			run(OP_TABLE_READ_HIGH, ROWA + 16'(2 * i), 16'h0000, 2'b00);
			rd(`FSP_HR_RDATA, v);
			chk(v, 32'h000000C0 + 32'(i));
		end
		run(OP_TABLE_READ_LOW, ROWA + 16'h0002, 16'h0000, 2'b11);
		rd(`FSP_HR_RDATA, v);
		chk(v, 32'h000000A5);
		// serial path writes one word
		wr(`FSP_HR_SCTL, 32'h00000001);
		wr(`FSP_HR_SADDR, 32'h00000100);
		#1 chk({31'h00000000, fsp_if_i.master_clear_pin_n}, 32'h00000000);
		wr(`FSP_HR_SDATA, 32'h00123456);
		wait_clear(2);
		wr(`FSP_HR_SCTL, 32'h00000000);
		run(OP_TABLE_READ_LOW, 16'h0100, 16'h0000, 2'b00);
		rd(`FSP_HR_RDATA, v);
		chk(v, 32'h00003456);
		run(OP_TABLE_READ_HIGH, 16'h0100, 16'h0000, 2'b00);
		rd(`FSP_HR_RDATA, v);
		chk(v, 32'h00000012);
		end_of_test();
	end
endmodule // flash_self_programming_tb
